// File: verilog/dsfn_consts.svh
// Register offsets, field positions, reset values and limits for the block.
`ifndef DSFN_CONSTS_SVH
`define DSFN_CONSTS_SVH
`define ST_FOUND 0
`define ST_SW_KNOWN 1
`define ST_LIVE 2
`define ST_ACCEPTED 3
`define ST_ERROR 6
`define ST_GIVEN_UP 7
`define ST_RSVD_LO 4
`define ST_RSVD_HI 5
`define STATUS_RST 8'h00
`define FEAT_BITS 64
`define FEAT_DEV_LAST 23
`define FEAT_EXT_FIRST 24
`define FEAT_EXT_LAST 37
`define FEAT_MODERN 32
`define OFF_STATUS 12'h000
`define OFF_OFFER_LO 12'h004
`define OFF_OFFER_HI 12'h008
`define OFF_ACCEPT_LO 12'h00c
`define OFF_ACCEPT_HI 12'h010
`define OFF_GEN 12'h014
`define OFF_NOTIFY 12'h018
`define OFF_FLAGS 12'h01c
`define OFF_CFG_BASE 12'h100
`define CFG_WORDS 4
`define CFG_IDX_LSB 2
`define CFG_IDX_W 2
`define REQ_BIT_W 6
`endif

// File: verilog/dsfn_pkg.sv
// Types shared by the status and feature negotiation block.
package dsfn_pkg;
  typedef logic [63:0] feat_t;
  typedef logic [7:0] status_t;
  typedef enum logic [1:0] {
    ph_reset = 2'b00,
    ph_negotiate = 2'b01,
    ph_running = 2'b11,
    ph_halted = 2'b10
  } phase_e;
endpackage : dsfn_pkg

// File: verilog/feature_check.sv
// Combinational check of an accepted feature set against offer and needs.
`include "dsfn_consts.svh"
module feature_check
  import dsfn_pkg::*;
#(
  parameter int NBITS = `FEAT_BITS,
  parameter logic [NBITS-1:0] NEED_MASK = '0,
  parameter int NEED_BIT = 0
)(
  input wire logic [NBITS-1:0] offered,
  input wire logic [NBITS-1:0] accepted,
  output logic ok
);
  // A feature in NEED_MASK is valid only with feature NEED_BIT as well.
  always_comb
  begin
    ok = ((accepted & ~offered) == '0);
    if (((accepted & NEED_MASK) != '0) && !accepted[NEED_BIT])
    begin
      ok = 1'b0;
    end
  end
endmodule : feature_check

// File: verilog/gen_counter.sv
// Configuration generation counter that steps on every content change.
`include "dsfn_consts.svh"
module gen_counter #(
  parameter int W = 32
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic bump,
  output logic [W-1:0] count
);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
    end
    else if (bump)
    begin
      count <= count + 1'b1;
    end
  end
endmodule : gen_counter

// File: verilog/dsfn_top.sv
// Device status, feature negotiation, notifications and config space.
// Summary of operation
// (RULE1) Status bits: found 1, known 2, live 4, accepted 8, error 64, given up 128.
// (RULE2) Device reset clears the whole status byte to zero.
// (RULE3) Software sets status bits one at a time and never clears them.
// (RULE4) After given up, software resets before trying again.
// (RULE5) With error set, software treats requests as unknown and resets.
// (RULE6) No buffer taking or used notifications before host software live.
// (RULE7) Fatal error sets error flag; notify config change when live.
// (RULE8) Feature bits 0-23 device type, 24-37 extensions, 38 up future.
// (RULE9) Accepted set is frozen once negotiated until a device reset.
// (RULE10) Software accepts only offered features and their prerequisites.
// (RULE11) Software falls back or sets given up if a feature lacks.
// (RULE12) Device never offers a feature without its prerequisite.
// (RULE13) Rejected accepted set leaves the accepted-status bit clear.
// (RULE14) A set once accepted is accepted again after any reset. The code remembers only the last accepted set, across device resets only; rstn clears it.
// (RULE15) Without modern feature acknowledged the device runs legacy mode.
// (RULE16) Device sends config and used notifications; host sends available.
// (RULE17) Multi-byte config fields are stored least significant byte first.
// (RULE18) Generation counter changes whenever config contents change.
// (RULE19) Software rereads generation around wide reads until it matches.
// (RULE20) Software checks a feature is offered before optional fields.
// (RULE21) Config fields read valid before negotiation is accepted.
// (RULE22) Software does not cap the config space size.
// (RULE23) Legacy software rereads capacity and address until stable.
// (RULE24) Separate offered and accepted vectors, checked on accept write.
`include "dsfn_consts.svh"
module dsfn_top
  import dsfn_pkg::*;
#(
  parameter feat_t OFFER = 64'h0000_0001_0000_0003,
  parameter feat_t NEED_MASK = 64'h0000_0000_0000_0002,
  parameter int NEED_BIT = 0,
  parameter int QW = 4
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fatal_error,
  input wire logic cfg_we,
  input wire logic [`CFG_IDX_W-1:0] cfg_idx,
  input wire logic [31:0] cfg_wdata,
  input wire logic used_req,
  input wire logic [QW-1:0] used_queue,
  output logic used_notify,
  output logic [QW-1:0] used_notify_queue,
  output logic config_notify,
  output logic avail_notify,
  output logic [QW-1:0] avail_notify_queue,
  output logic queues_enabled,
  output logic legacy_mode,
  output logic [7:0] status_out
);
  status_t status;
  feat_t accepted;
  feat_t remembered;
  logic remembered_vld;
  logic feat_ok;
  logic [31:0] cfg_mem [`CFG_WORDS];
  logic [31:0] gen;
  logic setup;
  logic wr;
  logic dev_reset;
  logic sel_ok;
  logic want_accept;
  logic negotiate_ok;
  status_t next_status;
  phase_e phase;

  // Checks the accepted set against OFFER and the NEED_MASK prerequisite; the offered set itself is not checked.
  feature_check #(.NBITS(`FEAT_BITS), .NEED_MASK(NEED_MASK),
    .NEED_BIT(NEED_BIT)) u_check (
    .offered(OFFER),
    .accepted(accepted),
    .ok(feat_ok)
  );

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `OFF_FLAGS) ||
      ((a >= `OFF_CFG_BASE) && (a < `OFF_CFG_BASE + 12'(4 * `CFG_WORDS)));
  endfunction : mapped

  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign sel_ok = mapped(paddr);
  // Writing zero to the status register is a device reset.
  assign dev_reset = wr && (paddr == `OFF_STATUS) &&
    (pwdata[7:0] == `STATUS_RST);
  assign want_accept = wr && (paddr == `OFF_STATUS) &&
    pwdata[`ST_ACCEPTED] && !status[`ST_ACCEPTED];
  // The set last accepted since rstn is accepted again after a device reset. [RULE14]
  assign negotiate_ok = feat_ok ||
    (remembered_vld && (remembered == accepted)); // [RULE24]

  // APB slave answers in the cycle after setup.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !sel_ok;
    end
  end

  always_comb
  begin
    next_status = status | pwdata[7:0];
    if (!negotiate_ok || status[`ST_ACCEPTED] == 1'b0 && phase != ph_negotiate)
    begin
      next_status[`ST_ACCEPTED] = status[`ST_ACCEPTED];
    end
    if (negotiate_ok && phase == ph_negotiate)
    begin
      next_status[`ST_ACCEPTED] = status[`ST_ACCEPTED] | pwdata[`ST_ACCEPTED];
    end
    next_status[`ST_ERROR] = status[`ST_ERROR];
    next_status[`ST_RSVD_HI:`ST_RSVD_LO] = '0;
  end

  // Status byte: software only sets bits; zero write resets. [RULE1] [RULE3]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status <= `STATUS_RST; // [RULE2]
    end
    else if (dev_reset)
    begin
      status <= `STATUS_RST; // [RULE2]
    end
    else
    begin
      if (wr && paddr == `OFF_STATUS)
      begin
        status <= next_status; // [RULE13]
      end
      if (fatal_error)
      begin
        status[`ST_ERROR] <= 1'b1; // [RULE7]
      end
    end
  end

  // Phase of the negotiation: running once accepted, halted on given up or error while running, held until reset. [RULE9]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase <= ph_reset;
    end
    else if (dev_reset)
    begin
      phase <= ph_reset;
    end
    else
    begin
      case (phase)
        ph_reset:
          if (wr && paddr == `OFF_STATUS)
          begin
            phase <= ph_negotiate;
          end
        ph_negotiate:
          if (want_accept && negotiate_ok)
          begin
            phase <= ph_running;
          end
        ph_running:
          if (status[`ST_GIVEN_UP] || status[`ST_ERROR])
          begin
            phase <= ph_halted;
          end
        ph_halted:
          phase <= ph_halted;
        default:
          phase <= ph_reset;
      endcase
    end
  end

  // Accepted vector writable only before acceptance. [RULE9] [RULE24]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      accepted <= '0;
    end
    else if (dev_reset)
    begin
      accepted <= '0;
    end
    else if (wr && !status[`ST_ACCEPTED])
    begin
      if (paddr == `OFF_ACCEPT_LO)
      begin
        accepted[31:0] <= pwdata;
      end
      if (paddr == `OFF_ACCEPT_HI)
      begin
        accepted[63:32] <= pwdata;
      end
    end
  end

  // Remember the last successfully accepted set across device resets; rstn clears it. [RULE14]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      remembered <= '0;
      remembered_vld <= 1'b0;
    end
    else if (want_accept && negotiate_ok && phase == ph_negotiate)
    begin
      remembered <= accepted;
      remembered_vld <= 1'b1;
    end
  end

  // Configuration words, little-endian byte lanes. [RULE17] [RULE21]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `CFG_WORDS; i++)
      begin
        cfg_mem[i] <= '0;
      end
    end
    else if (cfg_we)
    begin
      cfg_mem[cfg_idx] <= cfg_wdata;
    end
  end

  // Any content change steps the generation. [RULE18]
  gen_counter #(.W(32)) u_gen (
    .clk(clk),
    .rstn(rstn),
    .bump(cfg_we || fatal_error && !status[`ST_ERROR]),
    .count(gen)
  );

  // Read data mux.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= '0;
    end
    else if (setup && !pwrite)
    begin
      case (paddr)
        `OFF_STATUS: prdata <= {24'h0, status};
        `OFF_OFFER_LO: prdata <= OFFER[31:0]; // [RULE8] [RULE12]
        `OFF_OFFER_HI: prdata <= OFFER[63:32];
        `OFF_ACCEPT_LO: prdata <= accepted[31:0];
        `OFF_ACCEPT_HI: prdata <= accepted[63:32];
        `OFF_GEN: prdata <= gen;
        `OFF_FLAGS: prdata <= {30'h0, legacy_mode, queues_enabled};
        default:
          if (paddr >= `OFF_CFG_BASE && sel_ok)
          begin
            prdata <= cfg_mem[paddr[`CFG_IDX_LSB +: `CFG_IDX_W]]; // [RULE21]
          end
          else
          begin
            prdata <= '0;
          end
      endcase
    end
  end

  // Notifications in both directions. [RULE16]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      used_notify <= 1'b0;
      used_notify_queue <= '0;
      config_notify <= 1'b0;
      avail_notify <= 1'b0;
      avail_notify_queue <= '0;
    end
    else
    begin
      used_notify <= used_req && status[`ST_LIVE] &&
        !status[`ST_ERROR]; // [RULE6]
      used_notify_queue <= used_queue;
      config_notify <= status[`ST_LIVE] &&
        ((fatal_error && !status[`ST_ERROR]) || cfg_we); // [RULE7]
      avail_notify <= wr && paddr == `OFF_NOTIFY;
      avail_notify_queue <= pwdata[QW-1:0];
    end
  end

  // Queue enable and legacy mode outputs. [RULE6] [RULE15]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      queues_enabled <= 1'b0;
      legacy_mode <= 1'b0;
      status_out <= `STATUS_RST;
    end
    else
    begin
      queues_enabled <= status[`ST_LIVE] && !status[`ST_ERROR];
      legacy_mode <= status[`ST_ACCEPTED] && !accepted[`FEAT_MODERN];
      status_out <= status;
    end
  end

  property p_reset_clear;
    @(posedge clk) disable iff (!rstn)
    dev_reset |=> (status == `STATUS_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RULE2]
    else $error("status not cleared by device reset");

  property p_no_used_early;
    @(posedge clk) disable iff (!rstn)
    !status[`ST_LIVE] |=> !used_notify;
  endproperty
  a_no_used_early: assert property (p_no_used_early) // [RULE6]
    else $error("used notification before live");

  property p_err_notify;
    @(posedge clk) disable iff (!rstn)
    (fatal_error && !status[`ST_ERROR] && status[`ST_LIVE] && !dev_reset)
      |=> config_notify && status[`ST_ERROR];
  endproperty
  a_err_notify: assert property (p_err_notify) // [RULE7]
    else $error("error without config notification");

  property p_reject;
    @(posedge clk) disable iff (!rstn)
    (want_accept && !negotiate_ok) |=> !status[`ST_ACCEPTED];
  endproperty
  a_reject: assert property (p_reject) // [RULE13]
    else $error("invalid set accepted");

  property p_frozen;
    @(posedge clk) disable iff (!rstn)
    (status[`ST_ACCEPTED] && !dev_reset) |=> $stable(accepted);
  endproperty
  a_frozen: assert property (p_frozen) // [RULE9]
    else $error("accepted set changed after negotiation");

  property p_gen_step;
    @(posedge clk) disable iff (!rstn)
    cfg_we |=> gen != $past(gen);
  endproperty
  a_gen_step: assert property (p_gen_step) // [RULE18]
    else $error("generation did not change");

  property p_legacy;
    @(posedge clk) disable iff (!rstn)
    status[`ST_ACCEPTED] && !accepted[`FEAT_MODERN] ##1 status[`ST_ACCEPTED]
      |-> legacy_mode;
  endproperty
  a_legacy: assert property (p_legacy) // [RULE15]
    else $error("legacy mode not entered");

  property p_avail;
    @(posedge clk) disable iff (!rstn)
    (wr && paddr == `OFF_NOTIFY) |=> avail_notify ##1 !avail_notify;
  endproperty
  a_avail: assert property (p_avail) // [RULE16]
    else $error("available notification not pulsed");
endmodule : dsfn_top

// File: dv/dsfn_top_tb.sv
// Self-checking testbench for the status and feature negotiation block.
`include "dsfn_consts.svh"
module dsfn_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] OFFER = 64'h0000_0001_0000_0003;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fatal_error = 1'b0, cfg_we = 1'b0, used_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, cfg_wdata = 32'h0, prdata, rd, g0;
  logic [3:0] pstrb = 4'hf, used_queue = 4'h0;
  logic [3:0] used_notify_queue, avail_notify_queue, last_used, last_avail;
  logic [1:0] cfg_idx = 2'h0;
  logic pready, pslverr, err, used_notify, config_notify, avail_notify;
  logic queues_enabled, legacy_mode;
  logic [7:0] status_out;
  int fails = 0, n_compared = 0, n_used = 0, n_cfg = 0, n_avail = 0;

  dsfn_top #(.OFFER(OFFER)) dut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fatal_error(fatal_error), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_wdata(cfg_wdata), .used_req(used_req), .used_queue(used_queue),
    .used_notify(used_notify), .used_notify_queue(used_notify_queue),
    .config_notify(config_notify), .avail_notify(avail_notify),
    .avail_notify_queue(avail_notify_queue),
    .queues_enabled(queues_enabled), .legacy_mode(legacy_mode),
    .status_out(status_out));

  always #2 clk = ~clk;

  // Counts the notification pulses and keeps the queue each used and available one named.
  always @(posedge clk)
  begin
    if (used_notify === 1'b1)
    begin
      n_used <= n_used + 1;
      last_used <= used_notify_queue;
    end
    if (avail_notify === 1'b1)
    begin
      n_avail <= n_avail + 1;
      last_avail <= avail_notify_queue;
    end
    if (config_notify === 1'b1)
      n_cfg <= n_cfg + 1;
  end

  task automatic check(input string what, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; read data and error are taken with pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdchk

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic t_reset();
    check("status_out", status_out, 8'h00);
    rdchk("status", `OFF_STATUS, 32'h0);
    rdchk("offer lo", `OFF_OFFER_LO, OFFER[31:0]);
    check("need met", rd[1] & ~rd[0], 1'b0);
    rdchk("offer hi", `OFF_OFFER_HI, OFFER[63:32]);
    $display("test reset done");
  endtask : t_reset

  task automatic t_cfg();
    rdchk("gen", `OFF_GEN, 32'h0);
    g0 = rd;
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_idx <= 2'h1;
    cfg_wdata <= 32'h4433_2211;
    @(posedge clk);
    cfg_we <= 1'b0;
    settle();
    apb(1'b0, `OFF_GEN, 32'h0);
    check("gen moved", rd != g0, 1'b1);
    g0 = rd;
    rdchk("cfg word", `OFF_CFG_BASE + 12'h004, 32'h4433_2211);
    check("cfg lsb", rd[7:0], 8'h11);
    rdchk("gen steady", `OFF_GEN, g0);
    rdchk("cfg last", `OFF_CFG_BASE + 12'h00c, 32'h0);
    check("no cfg notify", n_cfg, 0);
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_negotiate();
    logic [31:0] bad [2] = '{32'h2, 32'h4};
    apb(1'b1, `OFF_STATUS, 32'h1);
    rdchk("found", `OFF_STATUS, 32'h1);
    apb(1'b1, `OFF_STATUS, 32'h3);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, `OFF_ACCEPT_LO, bad[i]);
      apb(1'b1, `OFF_ACCEPT_HI, 32'h1);
      apb(1'b1, `OFF_STATUS, 32'hb);
      rdchk("rejected", `OFF_STATUS, 32'h3);
    end
    apb(1'b1, `OFF_ACCEPT_LO, 32'h3);
    apb(1'b1, `OFF_STATUS, 32'hb);
    rdchk("accepted", `OFF_STATUS, 32'hb);
    check("modern", legacy_mode, 1'b0);
    apb(1'b1, `OFF_ACCEPT_LO, 32'h0);
    rdchk("frozen", `OFF_ACCEPT_LO, 32'h3);
    apb(1'b1, `OFF_STATUS, 32'h0);
    rdchk("cleared", `OFF_STATUS, 32'h0);
    rdchk("accept cleared", `OFF_ACCEPT_HI, 32'h0);
    apb(1'b1, `OFF_STATUS, 32'h1);
    apb(1'b1, `OFF_STATUS, 32'h3);
    apb(1'b1, `OFF_ACCEPT_LO, 32'h3);
    apb(1'b1, `OFF_ACCEPT_HI, 32'h1);
    apb(1'b1, `OFF_STATUS, 32'hb);
    rdchk("same set again", `OFF_STATUS, 32'hb);
    apb(1'b1, `OFF_STATUS, 32'h0);
    apb(1'b1, `OFF_STATUS, 32'h1);
    apb(1'b1, `OFF_STATUS, 32'h3);
    apb(1'b1, `OFF_ACCEPT_LO, 32'h3);
    apb(1'b1, `OFF_STATUS, 32'hb);
    rdchk("legacy set ok", `OFF_STATUS, 32'hb);
    settle();
    check("legacy", legacy_mode, 1'b1);
    rdchk("legacy read 1", `OFF_CFG_BASE + 12'h004, 32'h4433_2211);
    rdchk("legacy read 2", `OFF_CFG_BASE + 12'h004, 32'h4433_2211);
    $display("test negotiate done");
  endtask : t_negotiate

  task automatic t_live();
    @(posedge clk);
    used_req <= 1'b1;
    used_queue <= 4'h6;
    @(posedge clk);
    used_req <= 1'b0;
    settle();
    check("used early", n_used, 0);
    check("queues off", queues_enabled, 1'b0);
    apb(1'b1, `OFF_STATUS, 32'hf);
    @(posedge clk);
    used_req <= 1'b1;
    used_queue <= 4'h9;
    @(posedge clk);
    used_req <= 1'b0;
    settle();
    check("used count", n_used, 1);
    check("used queue", last_used, 4'h9);
    check("queues on", queues_enabled, 1'b1);
    apb(1'b1, `OFF_NOTIFY, 32'h5);
    settle();
    check("avail count", n_avail, 1);
    check("avail queue", last_avail, 4'h5);
    $display("test live done");
  endtask : t_live

  task automatic t_error();
    @(posedge clk);
    fatal_error <= 1'b1;
    @(posedge clk);
    fatal_error <= 1'b0;
    settle();
    rdchk("error bit", `OFF_STATUS, 32'h4f);
    check("cfg notify", n_cfg, 1);
    check("queues stop", queues_enabled, 1'b0);
    apb(1'b1, `OFF_STATUS, 32'h0);
    rdchk("reset", `OFF_STATUS, 32'h0);
    apb(1'b1, `OFF_STATUS, 32'h1);
    apb(1'b1, `OFF_STATUS, 32'h81);
    rdchk("given up", `OFF_STATUS, 32'h81);
    apb(1'b1, `OFF_STATUS, 32'h0);
    rdchk("restart", `OFF_STATUS, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test error done");
  endtask : t_error

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_cfg();
    t_negotiate();
    t_live();
    t_error();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : dsfn_top_tb
